// file: rtl/chuck_seq_map.svh
// Offsets, field positions, reset values and timing figures of the chuck sequencer.
// Assumes inclusion by bare name from the design file.
`ifndef CHUCK_SEQ_MAP_SVH
`define CHUCK_SEQ_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CFG_OFS 12'h000
`define CMD_OFS 12'h004
`define STAT_OFS 12'h008
`define HOLD_OFS 12'h00C
`define RESP_OFS 12'h010
`define ALM_OFS 12'h014
`define MODE_OFS 12'h018

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define CFG_FUNC_DIS 0
`define CFG_ILK_OFF 1
`define CFG_CONT_EN 2
`define CFG_INNER 3
`define CFG_FB_EN 4
`define CFG_PULSE 5
`define CFG_FOOT_DIS 6
`define CFG_CONT_ALM 7
`define CFG_RESET 8'h00

// ----------------------------------------
// Command fields (write one)
// ----------------------------------------
`define CMD_CLAMP 0
`define CMD_RELEASE 1
`define CMD_CANCEL 2
`define CMD_SPIN_START 3

// ----------------------------------------
// Alarm fields (write one to clear)
// ----------------------------------------
`define ALM_CLAMP_TO 0
`define ALM_RELEASE_TO 1
`define ALM_FOOT 2
`define ALM_ILK 3
`define ALM_SPIN 4
`define ALM_CONT 5

// ----------------------------------------
// Timing: defaults in milliseconds at 40 MHz
// ----------------------------------------
`define CLK_MHZ 40
`define HOLD_MS_DEF 16'h0064
`define RESP_MS_DEF 16'h03E8
`define MS_CYCLES (`CLK_MHZ * 1000)

`endif

// file: rtl/chuck_seq_pkg.sv
// Types shared by the chuck sequencer.
// Assumes the offsets live in chuck_seq_map.svh.
package chuck_seq_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DRIVE = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_DONE = 4'b1000
  } seq_state_e;
endpackage

// file: rtl/chuck_seq.sv
// Hydraulic chuck sequencer with AXI4-Lite register slave.
// Assumes feedback and foot-switch pins are asynchronous; spindle_running, machining and software on aclk.
// Functional notes
// - Sequencer works only while function-disable bit is zero.
// - Interlock bit zero enforces chuck versus spindle interlocking.
// - Continuous-check bit one monitors chuck feedback during operation.
// - Chuck-type bit one selects inner chuck, zero outer.
// - Feedback-check bit one verifies position; shows green or yellow.
// - Output-style bit zero gives level drive, one gives pulse.
// - Foot-switch disable bit zero makes foot switch effective, except in mode 2.
// - Clamp drives clamp output; completes now or waits for feedback.
// - Clamp check needs clamp feedback low, release high in time.
// - Release drives release output; check waits for opposite feedback.
// - Release check timeout raises release-response alarm.
// - Inner mode swaps the clamp and release output pins.
// - Each enabled foot press toggles between clamp and release.
// - Foot switch held as mode changes from zero to nonzero raises an alarm.
// - Pulse mode holds output for programmed hold time.
// - After reset chuck is released; first input clamps.
// - Interlocked command while spindle runs is refused with alarm.
// - Clamp and release commands accepted in manual jog mode.
// - Cancel withdraws both chuck outputs.
// - Interlocked spindle start while released is refused with alarm.
// - Failed or interrupted operation marks position unconfirmed; start permit follows clamped_r, or is given while inactive or with interlock bit one.
// - Abnormal release during machining with alarm option stops program, spindle.
`include "chuck_seq_map.svh"

module chuck_seq #(
  parameter int HOLD_MS = `HOLD_MS_DEF,
  parameter int RESP_MS = `RESP_MS_DEF,
  parameter int MS_CYCLES = `MS_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic clamp_feedback,
  input wire logic release_feedback,
  input wire logic foot_switch,
  input wire logic spindle_running,
  input wire logic machining,
  output logic clamp_out,
  output logic release_out,
  output logic lamp_green,
  output logic lamp_yellow,
  output logic pos_unconfirmed,
  output logic program_stop,
  output logic spindle_stop,
  output logic spindle_start_ok
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] cfb_sync_r, rfb_sync_r, foot_sync_r;
  logic cfb_r, rfb_r, foot_r, foot_prev_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfb_sync_r <= 3'h7;
      rfb_sync_r <= 3'h7;
      foot_sync_r <= 3'h0;
    end else begin
      cfb_sync_r <= {cfb_sync_r[1:0], clamp_feedback};
      rfb_sync_r <= {rfb_sync_r[1:0], release_feedback};
      foot_sync_r <= {foot_sync_r[1:0], foot_switch};
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfb_r <= 1'b1;
      rfb_r <= 1'b1;
      foot_r <= 1'b0;
      foot_prev_r <= 1'b0;
    end else begin
      if (cfb_sync_r[1] == cfb_sync_r[2]) cfb_r <= cfb_sync_r[2];
      if (rfb_sync_r[1] == rfb_sync_r[2]) rfb_r <= rfb_sync_r[2];
      if (foot_sync_r[1] == foot_sync_r[2]) foot_r <= foot_sync_r[2];
      foot_prev_r <= foot_r;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] cfg_r;
  logic [15:0] hold_ms_r, resp_ms_r;
  logic [5:0] alm_r;
  logic [1:0] mode_r;
  logic mode_prev_r;
  logic [3:0] cmd_pulse;
  logic [5:0] alm_set, alm_clr;

  logic aw_got_r, w_got_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;

  assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid;

  function automatic logic known(input logic [11:0] a);
    known = (a == `CFG_OFS) || (a == `CMD_OFS) || (a == `STAT_OFS) || (a == `HOLD_OFS) ||
            (a == `RESP_OFS) || (a == `ALM_OFS) || (a == `MODE_OFS);
  endfunction

  // Write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_got_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known(awaddr_r) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign cmd_pulse = (wr_go && awaddr_r == `CMD_OFS && wstrb_r[0]) ? wdata_r[3:0] : 4'h0;
  assign alm_clr = (wr_go && awaddr_r == `ALM_OFS && wstrb_r[0]) ? wdata_r[5:0] : 6'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= `CFG_RESET;
      hold_ms_r <= 16'(HOLD_MS);
      resp_ms_r <= 16'(RESP_MS);
      mode_r <= 2'h0;
    end else if (wr_go) begin
      if (awaddr_r == `CFG_OFS && wstrb_r[0]) cfg_r <= wdata_r[7:0];
      if (awaddr_r == `HOLD_OFS && wstrb_r[0]) hold_ms_r[7:0] <= wdata_r[7:0];
      if (awaddr_r == `HOLD_OFS && wstrb_r[1]) hold_ms_r[15:8] <= wdata_r[15:8];
      if (awaddr_r == `RESP_OFS && wstrb_r[0]) resp_ms_r[7:0] <= wdata_r[7:0];
      if (awaddr_r == `RESP_OFS && wstrb_r[1]) resp_ms_r[15:8] <= wdata_r[15:8];
      if (awaddr_r == `MODE_OFS && wstrb_r[0]) mode_r <= wdata_r[1:0];
    end
  end

  // Alarms: set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) alm_r <= 6'h00;
    else alm_r <= (alm_r & ~alm_clr) | alm_set;
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  chuck_seq_pkg::seq_state_e state_r;
  logic clamped_r, want_clamp_r, in_clamp, in_release, go_clamp, go_release, refuse;
  logic active, foot_press, jog, spin_req, clamp_fb_ok, rel_fb_ok;
  logic [31:0] cyc_r;
  logic [15:0] ms_r;

  assign active = !cfg_r[`CFG_FUNC_DIS];
  assign jog = mode_r == 2'h1;
  assign foot_press = foot_r && !foot_prev_r && !cfg_r[`CFG_FOOT_DIS] && mode_r != 2'h2;
  assign in_clamp = active && (cmd_pulse[`CMD_CLAMP] && jog || foot_press && !clamped_r);
  assign in_release = active && (cmd_pulse[`CMD_RELEASE] && jog || foot_press && clamped_r);
  assign refuse = !cfg_r[`CFG_ILK_OFF] && spindle_running;
  assign go_clamp = in_clamp && !refuse;
  // clamp wins when both are asked at once
  assign go_release = in_release && !in_clamp && !refuse;
  assign clamp_fb_ok = !cfb_r && rfb_r;
  assign rel_fb_ok = !rfb_r && cfb_r;
  assign spin_req = cmd_pulse[`CMD_SPIN_START];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= chuck_seq_pkg::ST_IDLE;
      clamped_r <= 1'b0;
      want_clamp_r <= 1'b0;
      cyc_r <= 32'h0000_0000;
      ms_r <= 16'h0000;
      clamp_out <= 1'b0;
      release_out <= 1'b0;
      pos_unconfirmed <= 1'b1;
    end else begin
      cyc_r <= (cyc_r == 32'(MS_CYCLES - 1)) ? 32'h0000_0000 : cyc_r + 32'h0000_0001;
      if (cyc_r == 32'(MS_CYCLES - 1)) ms_r <= ms_r + 16'h0001;
      if (go_clamp || go_release) begin
        want_clamp_r <= go_clamp;
        clamp_out <= go_clamp ^ cfg_r[`CFG_INNER];
        release_out <= go_release ^ cfg_r[`CFG_INNER];
        cyc_r <= 32'h0000_0000;
        ms_r <= 16'h0000;
        state_r <= chuck_seq_pkg::ST_DRIVE;
      end else if (active && cmd_pulse[`CMD_CANCEL]) begin
        clamp_out <= 1'b0;
        release_out <= 1'b0;
        if (state_r != chuck_seq_pkg::ST_IDLE) pos_unconfirmed <= 1'b1;
        state_r <= chuck_seq_pkg::ST_IDLE;
      end else begin
        unique case (state_r)
          chuck_seq_pkg::ST_IDLE: ;
          chuck_seq_pkg::ST_DRIVE: begin
            if (cfg_r[`CFG_PULSE] && ms_r >= hold_ms_r) begin
              clamp_out <= 1'b0;
              release_out <= 1'b0;
            end
            if (!cfg_r[`CFG_FB_EN]) begin
              clamped_r <= want_clamp_r;
              pos_unconfirmed <= 1'b0;
              state_r <= chuck_seq_pkg::ST_DONE;
            end else begin
              state_r <= chuck_seq_pkg::ST_WAIT;
            end
          end
          chuck_seq_pkg::ST_WAIT: begin
            if (cfg_r[`CFG_PULSE] && ms_r >= hold_ms_r) begin
              clamp_out <= 1'b0;
              release_out <= 1'b0;
            end
            if (want_clamp_r ? clamp_fb_ok : rel_fb_ok) begin
              clamped_r <= want_clamp_r;
              pos_unconfirmed <= 1'b0;
              state_r <= chuck_seq_pkg::ST_DONE;
            end else if (ms_r >= resp_ms_r) begin
              clamped_r <= want_clamp_r;
              pos_unconfirmed <= 1'b1;
              state_r <= chuck_seq_pkg::ST_DONE;
            end
          end
          chuck_seq_pkg::ST_DONE: begin
            if (cfg_r[`CFG_PULSE] && ms_r >= hold_ms_r) begin
              clamp_out <= 1'b0;
              release_out <= 1'b0;
              state_r <= chuck_seq_pkg::ST_IDLE;
            end else if (!cfg_r[`CFG_PULSE]) begin
              state_r <= chuck_seq_pkg::ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Alarm sources and supervision
  // ----------------------------------------
  logic cont_fault;
  assign cont_fault = active && cfg_r[`CFG_CONT_EN] && clamped_r &&
                      state_r == chuck_seq_pkg::ST_IDLE && !clamp_fb_ok;

  always_comb begin
    alm_set = 6'h00;
    alm_set[`ALM_CLAMP_TO] = state_r == chuck_seq_pkg::ST_WAIT && want_clamp_r &&
                             !clamp_fb_ok && ms_r >= resp_ms_r;
    alm_set[`ALM_RELEASE_TO] = state_r == chuck_seq_pkg::ST_WAIT && !want_clamp_r &&
                               !rel_fb_ok && ms_r >= resp_ms_r;
    alm_set[`ALM_FOOT] = active && mode_r != 2'h0 && !mode_prev_r && foot_r;
    alm_set[`ALM_ILK] = (in_clamp || in_release) && refuse;
    alm_set[`ALM_SPIN] = active && spin_req && !cfg_r[`CFG_ILK_OFF] && !clamped_r;
    alm_set[`ALM_CONT] = cont_fault;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_prev_r <= 1'b0;
      lamp_green <= 1'b0;
      lamp_yellow <= 1'b0;
      program_stop <= 1'b0;
      spindle_stop <= 1'b0;
      spindle_start_ok <= 1'b0;
    end else begin
      mode_prev_r <= mode_r != 2'h0;
      lamp_green <= active && cfg_r[`CFG_FB_EN] && (clamped_r ? clamp_fb_ok : rel_fb_ok);
      lamp_yellow <= active && cfg_r[`CFG_FB_EN] && !(clamped_r ? clamp_fb_ok : rel_fb_ok);
      if (cont_fault && machining && cfg_r[`CFG_CONT_ALM]) begin
        program_stop <= 1'b1;
        spindle_stop <= 1'b1;
      end else if (!alm_r[`ALM_CONT]) begin
        program_stop <= 1'b0;
        spindle_stop <= 1'b0;
      end
      spindle_start_ok <= !active || cfg_r[`CFG_ILK_OFF] || clamped_r;
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= known(s_axi_araddr) ? 2'h0 : 2'h2;
        unique case (s_axi_araddr)
          `CFG_OFS: s_axi_rdata <= {24'h000000, cfg_r};
          `STAT_OFS: s_axi_rdata <= {24'h000000, cfb_r, rfb_r, clamped_r,
                                     pos_unconfirmed, state_r};
          `HOLD_OFS: s_axi_rdata <= {16'h0000, hold_ms_r};
          `RESP_OFS: s_axi_rdata <= {16'h0000, resp_ms_r};
          `ALM_OFS: s_axi_rdata <= {26'h000000, alm_r};
          `MODE_OFS: s_axi_rdata <= {30'h0000000, mode_r};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// file: testbench/chuck_seq_props.sv
// Port-level assertions on the chuck sequencer.
// Assumes one aclk domain and a bind onto chuck_seq.
module chuck_seq_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic machining,
  input wire logic clamp_out,
  input wire logic release_out,
  input wire logic lamp_green,
  input wire logic lamp_yellow,
  input wire logic pos_unconfirmed,
  input wire logic program_stop,
  input wire logic spindle_stop
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------
  // Sequences
  // ----------------
  sequence both_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence late_b_s;
    !s_axi_bvalid ##[1:3] s_axi_bvalid;
  endsequence
  sequence bad_aw_s;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr > 12'h018;
  endsequence
  // ----------------
  // Properties
  // ----------------
  a_write_answer: assert property (both_taken_s |=> late_b_s)
    else $error("write response out of window");
  a_bad_write: assert property (bad_aw_s |-> ##[1:8] s_axi_bvalid && s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h018
    |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_one_drive: assert property (!(clamp_out && release_out))
    else $error("clamp and release driven together");
  a_lamp_excl: assert property (!(lamp_green && lamp_yellow))
    else $error("both lamps lit");
  a_reset_unconf: assert property ($rose(aresetn) |-> pos_unconfirmed)
    else $error("position confirmed after reset");
  a_stop_pair: assert property ($rose(program_stop)
    |-> $past(machining) ##[0:2] spindle_stop)
    else $error("program stop without machining or spindle stop");
endmodule

bind chuck_seq chuck_seq_props props (.*);

// file: testbench/chuck_valves.sv
// Hydraulic valves and position switches behind the sequencer pins.
// Assumes the drives are already pin-swapped by the sequencer in inner mode.
module chuck_valves (
  input wire logic aclk,
  input wire logic clamp_out,
  input wire logic release_out,
  input wire logic inner,
  input wire logic stuck,
  input wire logic drop,
  output logic clamp_feedback,
  output logic release_feedback
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pos_r = 1'h0;
  int cnt_r = 0;
  wire logic clamp_drv = inner ? release_out : clamp_out;
  wire logic rel_drv = inner ? clamp_out : release_out;
  always @(posedge aclk) begin
    if (drop) begin
      pos_r <= 1'h0;
    end else if (!stuck && clamp_drv != rel_drv && pos_r != clamp_drv) begin
      cnt_r <= cnt_r + 1;
      if (cnt_r >= 1) begin
        pos_r <= clamp_drv;
        cnt_r <= 0;
      end
    end
  end
  assign clamp_feedback = !pos_r;
  assign release_feedback = pos_r;
endmodule

// file: testbench/hydraulic_chuck_sequencer_tb_top.sv
// Self-checking bench for the chuck sequencer over AXI4-Lite.
// Assumes chuck_seq, its checker and the valve model compile first.
`include "chuck_seq_map.svh"
module hydraulic_chuck_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, foot_switch = 0, spindle_running = 0;
  logic machining = 0, inner = 0, stuck = 0, drop = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic clamp_feedback, release_feedback, clamp_out, release_out, lamp_green;
  logic lamp_yellow, pos_unconfirmed, program_stop, spindle_stop, spindle_start_ok;
  logic [7:0] rnd = 8'h5B;
  int failures = 0, checks_done = 0, cyc = 0, act = 0, n = 0, h = 0;

  // Short millisecond so every timed step stays a few cycles
  chuck_seq #(.MS_CYCLES(4)) dut (.*);
  chuck_valves valves (.*);

  initial forever #12.5 aclk = ~aclk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic cmd(input logic [31:0] c);
    wr(`CMD_OFS, c);
    repeat (3) @(posedge aclk);
  endtask

  // Expected pins from the held action: 1 clamp, 2 release, 0 none
  task automatic outs(input int a);
    check(clamp_out, inner ? a == 2 : a == 1);
    check(release_out, inner ? a == 1 : a == 2);
  endtask

  task automatic alarm(input logic [31:0] e);
    rd(`ALM_OFS);
    check(rdat, e);
    wr(`ALM_OFS, 32'h3F);
  endtask

  task automatic op(input logic [31:0] c, input logic s, input logic [31:0] e);
    stuck <= s;
    cmd(c);
    repeat (30) @(posedge aclk);
    check(lamp_green, e == 0);
    check(lamp_yellow, e != 0);
    check(pos_unconfirmed, e != 0);
    alarm(e);
  endtask

  task automatic press;
    foot_switch <= 1'h1;
    repeat (6) @(posedge aclk);
    foot_switch <= 1'h0;
    repeat (6) @(posedge aclk);
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`CFG_OFS);
    check(rdat, 32'h0);
    check(pos_unconfirmed, 1'h1);
    rd(12'h100);
    check(resp, 2'h2);
    wr(12'h100, 32'h1);
    check(resp, 2'h2);
    wr(`MODE_OFS, 32'h1);
    for (int i = 1; i <= 3; i++) begin
      cmd(32'h1 << (i - 1));
      act = i % 3;
      outs(act);
    end
    // Clamp and release asked in one write
    cmd(32'h3);
    check(clamp_out & release_out, 1'h0);
    cmd(32'h4);
    inner <= 1'h1;
    wr(`CFG_OFS, 32'h8);
    for (int i = 1; i <= 2; i++) begin
      cmd(i);
      outs(i);
    end
    cmd(32'h4);
    inner <= 1'h0;
    // Pulse width drawn at random, counted in high cycles
    rnd = lfsr(rnd);
    h = 1 + rnd % 3;
    wr(`HOLD_OFS, h);
    wr(`CFG_OFS, 32'h20);
    wr(`CMD_OFS, 32'h1);
    n = 0;
    repeat (60) begin
      @(posedge aclk);
      n += clamp_out;
    end
    check(n >= h * 4 - 3 && n <= h * 4 + 4, 1'h1);
    wr(`RESP_OFS, 32'h3);
    wr(`CFG_OFS, 32'h10);
    op(32'h2, 1'h1, 32'h2);
    op(32'h2, 1'h0, 32'h0);
    op(32'h1, 1'h1, 32'h1);
    op(32'h1, 1'h0, 32'h0);
    wr(`CFG_OFS, 32'h0);
    act = 1;
    for (int i = 0; i < 2; i++) begin
      press();
      act = 3 - act;
      outs(act);
    end
    wr(`CFG_OFS, 32'h40);
    press();
    outs(act);
    // Foot held across a mode change on purpose
    wr(`CFG_OFS, 32'h0);
    wr(`MODE_OFS, 32'h0);
    foot_switch <= 1'h1;
    repeat (6) @(posedge aclk);
    wr(`MODE_OFS, 32'h1);
    foot_switch <= 1'h0;
    alarm(32'h4);
    act = 2;
    spindle_running <= 1'h1;
    cmd(32'h1);
    outs(act);
    alarm(32'h8);
    wr(`CFG_OFS, 32'h2);
    cmd(32'h1);
    outs(1);
    check(spindle_start_ok, 1'h1);
    spindle_running <= 1'h0;
    wr(`CFG_OFS, 32'h0);
    cmd(32'h2);
    cmd(32'h8);
    check(spindle_start_ok, 1'h0);
    alarm(32'h10);
    cmd(32'h4);
    wr(`CFG_OFS, 32'h1);
    cmd(32'h1);
    outs(0);
    wr(`CFG_OFS, 32'h94);
    cmd(32'h1);
    repeat (20) @(posedge aclk);
    machining <= 1'h1;
    drop <= 1'h1;
    repeat (10) @(posedge aclk);
    drop <= 1'h0;
    repeat (5) @(posedge aclk);
    check(program_stop, 1'h1);
    check(spindle_stop, 1'h1);
    // Mid-run reset: position unconfirmed, first input clamps
    machining <= 1'h0;
    aresetn <= 1'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    check(pos_unconfirmed, 1'h1);
    check(program_stop, 1'h0);
    press();
    outs(1);
    check(pos_unconfirmed, 1'h0);
    test_done();
  end
endmodule
